// >>> design/ubrl_loader.sv
// ubrl_loader: serial boot loader running the ram load session.
// Assumes the serial line idles high from reset, that the stored password
// and the protection level are stable, and that the ram accepts one
// write per cycle.
//
// How it works
// - receiver off; first low run times baud
// - unusable baud: stop silently, no reply
// - load baud, enable receiver, then send sync
// - command receive error replies low nibble 8
// - good command, no protection: echo, load
// - protection active replies low nibble 6
// - unknown command replies low nibble 1
// - twelve password bytes compared in order
// - nonzero field sum replies checksum error
// - receive error replies comm error first
// - password mismatch replies checksum error code
// - good password replies ok, header follows
// - header checked alike; ok lets payload follow
// - payload written to successive ram addresses
// - after final ok, jump to start
`timescale 1ns/1ps
module ubrl_loader #(
    parameter int CNT_W = 16,
    parameter int DEPTH = 2
) (
    input  wire logic                              ref_clk_in,
    input  wire logic                              rst_in,
    input  wire logic                              serial_rx_in,
    output logic                                   serial_tx_out,
    input  wire logic                              protect_active_in,
    input  wire logic [ubrl_pkg::PWD_BYTES*8-1:0]  password_in,
    output ubrl_pkg::ubrl_ram_wr_t                 ram_wr_out,
    output logic                                   jump_out,
    output logic [ubrl_pkg::ADDR_W-1:0]            jump_addr_out,
    output logic                                   session_dead_out,
    output logic                                   receive_enable_bit_out,
    output logic [CNT_W-1:0]                       baud_divider_control_out,
    output logic                                   baud_fraction_adjust_out
);
    import ubrl_pkg::*;

    localparam logic [CNT_W-1:0] MIN_RUN =
        CNT_W'(SYNC_LOW_BITS * MIN_BIT_CYC);
    localparam logic [LEN_W-1:0] PWD_END = LEN_W'(PWD_BYTES);
    localparam logic [LEN_W-1:0] HDR_END = LEN_W'(HDR_BYTES);
    localparam logic [3:0]       REST    = 4'(SYNC_REST_BITS);

    if (CNT_W < 6 || CNT_W > 24 || SYNC_LOW_BITS != 2) begin : g_chk
        $error("ubrl_loader: unsupported parameter values");
    end

    typedef struct packed {
        ubrl_state_t             st;
        ubrl_state_t             ret;
        logic [CNT_W-1:0]        cnt;
        logic [3:0]              bitn;
        logic [CNT_W-1:0]        div;
        logic                    frac;
        logic                    rxen;
        logic                    dead;
        logic [7:0]              last_cmd;
        logic [7:0]              reply;
        logic [LEN_W-1:0]        idx;
        logic [7:0]              sum;
        logic                    err;
        logic                    pw_ok;
        logic [ADDR_W+LEN_W-1:0] hdr;
        logic [ADDR_W-1:0]       ptr;
        ubrl_ram_wr_t            wr;
        logic                    jump;
    } ubrl_loader_st_t;

    ubrl_loader_st_t s_r;
    ubrl_loader_st_t s_nxt;
    logic            rx_valid;
    logic [7:0]      rx_data;
    logic            rx_error;
    logic            tx_valid;
    logic            tx_ready;
    logic            tx_idle;
    logic [7:0]      sum_all;

    // verdict on a closed field: receive error outranks checksum
    function automatic logic [7:0] verdict(input logic e,
                                           input logic [7:0] s);
        if (e) begin
            verdict = ACK_COMM_ERR;
        end else if (s != SUM_ZERO) begin
            verdict = ACK_SUM_ERR;
        end else begin
            verdict = ACK_OK;
        end
    endfunction : verdict

    // ------------------------------------------------------------------
    // serial line
    // ------------------------------------------------------------------
    ubrl_uart #(
        .DATA_W (8),
        .DEPTH  (DEPTH),
        .CNT_W  (CNT_W)
    ) u_uart (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .bit_div_in    (s_r.div),
        .frac_in       (s_r.frac),
        .rx_enable_in  (s_r.rxen),
        .serial_rx_in  (serial_rx_in),
        .rx_valid_out  (rx_valid),
        .rx_data_out   (rx_data),
        .rx_error_out  (rx_error),
        .tx_valid_in   (tx_valid),
        .tx_data_in    (s_r.reply),
        .tx_ready_out  (tx_ready),
        .tx_idle_out   (tx_idle),
        .serial_tx_out (serial_tx_out)
    );

    // a reply is offered while waiting in the send state
    assign tx_valid = (s_r.st == UBRL_SEND);
    assign sum_all  = s_r.sum + rx_data;

    // ------------------------------------------------------------------
    // session sequencer
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt       = s_r;
        s_nxt.wr.we = 1'b0;
        s_nxt.jump  = 1'b0;
        case (s_r.st)
            UBRL_WAIT_START: begin
                // receiver stays off while the sync byte is timed
                if (!serial_rx_in) begin
                    s_nxt.st  = UBRL_MEASURE;
                    s_nxt.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            UBRL_MEASURE: begin
                if (!serial_rx_in) begin
                    if (&s_r.cnt) begin
                        s_nxt.st = UBRL_DEAD;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 1'b1;
                    end
                end else if (s_r.cnt < MIN_RUN) begin
                    s_nxt.st = UBRL_DEAD;
                end else begin
                    // two bit times measured: halve, keep the half cycle
                    s_nxt.div  = {1'b0, s_r.cnt[CNT_W-1:1]};
                    s_nxt.frac = s_r.cnt[0];
                    s_nxt.bitn = '0;
                    s_nxt.cnt  = {1'b0, s_r.cnt[CNT_W-1:1]} - 1'b1;
                    s_nxt.st   = UBRL_SKIP;
                end
            end
            UBRL_SKIP: begin
                // let the rest of the sync byte pass before listening
                if (s_r.cnt != '0) begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end else if (s_r.bitn == REST - 4'h1) begin
                    s_nxt.rxen  = 1'b1;
                    s_nxt.reply = SYNC_BYTE;
                    s_nxt.ret   = UBRL_CMD;
                    s_nxt.st    = UBRL_SEND;
                end else begin
                    s_nxt.bitn = s_r.bitn + 1'b1;
                    s_nxt.cnt  = s_r.div - 1'b1
                               + {{(CNT_W-1){1'b0}},
                                  s_r.frac & ~s_r.bitn[0]};
                end
            end
            UBRL_DEAD: begin
                s_nxt.dead = 1'b1;
            end
            UBRL_CMD: begin
                if (rx_valid) begin
                    s_nxt.st  = UBRL_SEND;
                    s_nxt.ret = UBRL_CMD;
                    if (rx_error) begin
                        s_nxt.reply = {s_r.last_cmd[7:4], LOW_COMM};
                    end else begin
                        s_nxt.last_cmd = rx_data;
                        if (rx_data != CMD_RAM_LOAD) begin
                            s_nxt.reply = {s_r.last_cmd[7:4],
                                           LOW_BADCMD};
                        end else if (protect_active_in) begin
                            s_nxt.reply = {s_r.last_cmd[7:4],
                                           LOW_PROT};
                        end else begin
                            s_nxt.reply = rx_data;
                            s_nxt.ret   = UBRL_PWD;
                            s_nxt.idx   = '0;
                            s_nxt.sum   = '0;
                            s_nxt.err   = 1'b0;
                            s_nxt.pw_ok = 1'b1;
                        end
                    end
                end
            end
            UBRL_PWD: begin
                if (rx_valid) begin
                    s_nxt.err = s_r.err | rx_error;
                    if (s_r.idx != PWD_END) begin
                        // byte n meets stored byte n
                        s_nxt.pw_ok = s_r.pw_ok & (rx_data ==
                            password_in[8*int'(s_r.idx[3:0]) +: 8]);
                        s_nxt.sum   = sum_all;
                        s_nxt.idx   = s_r.idx + 1'b1;
                    end else begin
                        s_nxt.st    = UBRL_SEND;
                        s_nxt.reply = verdict(s_r.err | rx_error, sum_all);
                        if (s_nxt.reply == ACK_OK && !s_r.pw_ok) begin
                            s_nxt.reply = ACK_SUM_ERR;
                        end
                        s_nxt.ret   = (s_nxt.reply == ACK_OK) ?
                                      UBRL_HDR : UBRL_CMD;
                        s_nxt.idx   = '0;
                        s_nxt.sum   = '0;
                        s_nxt.err   = 1'b0;
                    end
                end
            end
            UBRL_HDR: begin
                if (rx_valid) begin
                    s_nxt.err = s_r.err | rx_error;
                    if (s_r.idx != HDR_END) begin
                        // address high byte first, then count high first
                        s_nxt.hdr = {s_r.hdr[ADDR_W+LEN_W-9:0],
                                     rx_data};
                        s_nxt.sum = sum_all;
                        s_nxt.idx = s_r.idx + 1'b1;
                    end else begin
                        s_nxt.st    = UBRL_SEND;
                        s_nxt.reply = verdict(s_r.err | rx_error,
                                              sum_all);
                        s_nxt.ret   = (s_nxt.reply == ACK_OK) ?
                                      UBRL_DATA : UBRL_CMD;
                        s_nxt.ptr   = s_r.hdr[ADDR_W+LEN_W-1:LEN_W];
                        s_nxt.idx   = '0;
                        s_nxt.sum   = '0;
                        s_nxt.err   = 1'b0;
                    end
                end
            end
            UBRL_DATA: begin
                if (rx_valid) begin
                    s_nxt.err = s_r.err | rx_error;
                    if (s_r.idx != s_r.hdr[LEN_W-1:0]) begin
                        s_nxt.wr.we   = 1'b1;
                        s_nxt.wr.addr = s_r.ptr;
                        s_nxt.wr.data = rx_data;
                        s_nxt.ptr     = s_r.ptr + 1'b1;
                        s_nxt.sum     = sum_all;
                        s_nxt.idx     = s_r.idx + 1'b1;
                    end else begin
                        s_nxt.st    = UBRL_SEND;
                        s_nxt.reply = verdict(s_r.err | rx_error, sum_all);
                        s_nxt.ret   = (s_nxt.reply == ACK_OK) ?
                                      UBRL_JUMP : UBRL_CMD;
                    end
                end
            end
            UBRL_SEND: begin
                if (tx_ready) begin
                    s_nxt.st = s_r.ret;
                end
            end
            UBRL_JUMP: begin
                // hand over only once the last reply has left the pin
                if (tx_idle) begin
                    s_nxt.jump = 1'b1;
                    s_nxt.st   = UBRL_DONE;
                end
            end
            default: begin
                s_nxt.st = UBRL_DONE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r     <= '0;
            s_r.st  <= UBRL_WAIT_START;
            s_r.ret <= UBRL_CMD;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state flops
    assign ram_wr_out               = s_r.wr;
    assign jump_out                 = s_r.jump;
    assign jump_addr_out            = s_r.hdr[ADDR_W+LEN_W-1:LEN_W];
    assign session_dead_out         = s_r.dead;
    assign receive_enable_bit_out   = s_r.rxen;
    assign baud_divider_control_out = s_r.div;
    assign baud_fraction_adjust_out = s_r.frac;

endmodule : ubrl_loader

// >>> design/ubrl_pkg.sv
// ubrl_pkg: constants and types shared by the serial RAM boot loader.
// Assumes nothing of its surroundings; imported by every design file.
package ubrl_pkg;

    // ------------------------------------------------------------------
    // protocol bytes
    // ------------------------------------------------------------------
    localparam logic [7:0] SYNC_BYTE    = 8'h86; // baud sync and its echo
    localparam logic [7:0] CMD_RAM_LOAD = 8'h10; // ram load command
    localparam logic [7:0] ACK_OK       = 8'h10; // field accepted
    localparam logic [7:0] ACK_SUM_ERR  = 8'h11; // checksum or password
    localparam logic [7:0] ACK_COMM_ERR = 8'h18; // receive error in field
    localparam logic [3:0] LOW_COMM     = 4'h8;  // command receive error
    localparam logic [3:0] LOW_PROT     = 4'h6;  // protection active
    localparam logic [3:0] LOW_BADCMD   = 4'h1;  // unknown command
    localparam logic [7:0] SUM_ZERO     = 8'h00; // good field sum

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int PWD_BYTES = 12; // password length
    localparam int HDR_BYTES = 6;  // four address bytes, two count bytes
    localparam int ADDR_W    = 32;
    localparam int LEN_W     = 16;

    // ------------------------------------------------------------------
    // baud measurement
    // ------------------------------------------------------------------
    // the sync byte starts with start bit and a zero bit: a low run of
    // two bit times, followed by eight more bit times up to the stop end
    localparam int SYNC_LOW_BITS  = 2;
    localparam int SYNC_REST_BITS = 8;
    localparam int MIN_BIT_CYC    = 4; // shortest bit the receiver serves

    // ------------------------------------------------------------------
    // loader states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        UBRL_WAIT_START,
        UBRL_MEASURE,
        UBRL_SKIP,
        UBRL_DEAD,
        UBRL_CMD,
        UBRL_PWD,
        UBRL_HDR,
        UBRL_DATA,
        UBRL_SEND,
        UBRL_JUMP,
        UBRL_DONE
    } ubrl_state_t;

    // ram write port carried as one group
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } ubrl_ram_wr_t;

endpackage : ubrl_pkg

// >>> design/ubrl_uart.sv
// ubrl_uart: 8n1 receiver and transmitter with a small transmit buffer.
// Assumes the bit time is set before the receiver is enabled and that the
// serial input is synchronous to ref_clk_in.
`timescale 1ns/1ps
module ubrl_uart #(
    parameter int DATA_W = 8,
    parameter int DEPTH  = 2,
    parameter int CNT_W  = 16
) (
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    input  wire logic [CNT_W-1:0]  bit_div_in,
    input  wire logic              frac_in,
    input  wire logic              rx_enable_in,
    input  wire logic              serial_rx_in,
    output logic                   rx_valid_out,
    output logic [DATA_W-1:0]      rx_data_out,
    output logic                   rx_error_out,
    input  wire logic              tx_valid_in,
    input  wire logic [DATA_W-1:0] tx_data_in,
    output logic                   tx_ready_out,
    output logic                   tx_idle_out,
    output logic                   serial_tx_out
);
    import ubrl_pkg::*;

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DATA_W < 5 || DATA_W > 12 || DEPTH < 2 || CNT_W < 4) begin : g_chk
        $error("ubrl_uart: unsupported parameter values");
    end

    typedef struct packed {
        logic                         rx_busy;
        logic [CNT_W-1:0]             rx_cnt;
        logic [3:0]                   rx_bit;
        logic [DATA_W-1:0]            rx_sh;
        logic                         rx_valid;
        logic [DATA_W-1:0]            rx_data;
        logic                         rx_err;
        logic                         tx_busy;
        logic [CNT_W-1:0]             tx_cnt;
        logic [3:0]                   tx_bit;
        logic [DATA_W+1:0]            tx_sh;
        logic                         tx_line;
        logic [DEPTH-1:0][DATA_W-1:0] mem;
        logic [PTR_W-1:0]             wp;
        logic [PTR_W-1:0]             rp;
        logic [PTR_W:0]               used;
    } ubrl_uart_st_t;

    ubrl_uart_st_t s_r;
    ubrl_uart_st_t s_nxt;
    logic          push;
    logic          pop;

    // cycles of one bit less one; odd bits take the half-cycle fraction
    function automatic logic [CNT_W-1:0] bit_len(input logic [3:0] b);
        bit_len = bit_div_in - 1'b1 + {{(CNT_W-1){1'b0}}, frac_in & b[0]};
    endfunction : bit_len

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    // buffer handshake; a full buffer stalls the loader
    assign tx_ready_out = (s_r.used < (PTR_W+1)'(DEPTH));
    assign push         = tx_valid_in & tx_ready_out;
    assign pop          = ~s_r.tx_busy & (s_r.used != '0);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt          = s_r;
        s_nxt.rx_valid = 1'b0;
        // receiver: half bit to the start middle, then whole bits
        if (!rx_enable_in) begin
            s_nxt.rx_busy = 1'b0;
        end else if (!s_r.rx_busy) begin
            if (!serial_rx_in) begin
                s_nxt.rx_busy = 1'b1;
                s_nxt.rx_bit  = '0;
                s_nxt.rx_cnt  = {1'b0, bit_div_in[CNT_W-1:1]};
            end
        end else if (s_r.rx_cnt != '0) begin
            s_nxt.rx_cnt = s_r.rx_cnt - 1'b1;
        end else if (s_r.rx_bit == '0) begin
            s_nxt.rx_busy = ~serial_rx_in; // glitch is no start
            s_nxt.rx_bit  = 4'h1;
            s_nxt.rx_cnt  = bit_len(4'h1);
        end else if (s_r.rx_bit <= 4'(DATA_W)) begin
            s_nxt.rx_sh  = {serial_rx_in, s_r.rx_sh[DATA_W-1:1]};
            s_nxt.rx_bit = s_r.rx_bit + 1'b1;
            s_nxt.rx_cnt = bit_len(s_r.rx_bit + 1'b1);
        end else begin
            s_nxt.rx_busy  = 1'b0;
            s_nxt.rx_valid = 1'b1;
            s_nxt.rx_data  = s_r.rx_sh;
            s_nxt.rx_err   = ~serial_rx_in; // framing error
        end
        // transmitter: start, data lsb first, one stop
        if (pop) begin
            s_nxt.tx_busy = 1'b1;
            s_nxt.tx_sh   = {1'b1, s_r.mem[s_r.rp], 1'b0};
            s_nxt.tx_bit  = '0;
            s_nxt.tx_cnt  = bit_len(4'h0);
            s_nxt.rp      = ptr_inc(s_r.rp);
        end else if (s_r.tx_busy) begin
            if (s_r.tx_cnt != '0) begin
                s_nxt.tx_cnt = s_r.tx_cnt - 1'b1;
            end else if (s_r.tx_bit == 4'(DATA_W + 1)) begin
                s_nxt.tx_busy = 1'b0;
            end else begin
                s_nxt.tx_sh  = {1'b1, s_r.tx_sh[DATA_W+1:1]};
                s_nxt.tx_bit = s_r.tx_bit + 1'b1;
                s_nxt.tx_cnt = bit_len(s_r.tx_bit + 1'b1);
            end
        end
        s_nxt.tx_line = s_nxt.tx_busy ? s_nxt.tx_sh[0] : 1'b1;
        // buffer fill side
        if (push) begin
            s_nxt.mem[s_r.wp] = tx_data_in;
            s_nxt.wp          = ptr_inc(s_r.wp);
        end
        s_nxt.used = s_r.used + {{PTR_W{1'b0}}, push}
                   - {{PTR_W{1'b0}}, pop};
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r         <= '0;
            s_r.tx_line <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rx_valid_out  = s_r.rx_valid;
    assign rx_data_out   = s_r.rx_data;
    assign rx_error_out  = s_r.rx_err;
    assign serial_tx_out = s_r.tx_line;
    assign tx_idle_out   = ~s_r.tx_busy & (s_r.used == '0);

endmodule : ubrl_uart

// >>> verification/ubrl_loader_sva.sv
// ubrl_loader_sva: port checks on the ram boot loader.
// Assumes it is bound into ubrl_loader; one clock, async reset.
`timescale 1ns/1ps
module ubrl_loader_sva #(
    parameter int CNT_W = 16
) (
    input wire logic                   ref_clk_in,
    input wire logic                   rst_in,
    input wire logic                   serial_tx_out,
    input wire ubrl_pkg::ubrl_ram_wr_t ram_wr_out,
    input wire logic                   jump_out,
    input wire logic                   session_dead_out,
    input wire logic                   receive_enable_bit_out,
    input wire logic [CNT_W-1:0]       baud_divider_control_out
);
    import ubrl_pkg::*;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ----
    // link and session checks
    // ----
    dead_quiet_a: assert property (session_dead_out |-> serial_tx_out)
        else $error("dead session drove the line");
    dead_no_rx_a: assert property (
        session_dead_out |-> !receive_enable_bit_out)
        else $error("dead session enabled the receiver");
    tx_needs_rx_a: assert property (
        !receive_enable_bit_out |-> serial_tx_out)
        else $error("reply sent before receiver enabled");
    rx_en_first_a: assert property (
        $rose(receive_enable_bit_out) |-> serial_tx_out [*2])
        else $error("sync echo not after receiver enable");
    baud_hold_a: assert property (
        receive_enable_bit_out |=> $stable(baud_divider_control_out))
        else $error("bit time moved after enable");
    baud_min_a: assert property (receive_enable_bit_out |->
        baud_divider_control_out >= CNT_W'(MIN_BIT_CYC))
        else $error("receiver enabled at unusable bit time");
    jump_once_a: assert property (jump_out |=> !jump_out [*8])
        else $error("jump not a single pulse");
    jump_idle_a: assert property (
        jump_out |-> serial_tx_out && !ram_wr_out.we)
        else $error("jump while line busy or writing");
    wr_pulse_a: assert property (ram_wr_out.we |=> !ram_wr_out.we)
        else $error("ram write strobe too long");
    cover property (jump_out);
    cover property (session_dead_out);
    cover property (ram_wr_out.we);
endmodule : ubrl_loader_sva

bind ubrl_loader ubrl_loader_sva #(.CNT_W(CNT_W)) chk_u (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .serial_tx_out(serial_tx_out),
    .ram_wr_out(ram_wr_out), .jump_out(jump_out),
    .session_dead_out(session_dead_out),
    .receive_enable_bit_out(receive_enable_bit_out),
    .baud_divider_control_out(baud_divider_control_out));

// >>> verification/ubrl_ctrl_model.sv
// ubrl_ctrl_model: behavioural boot controller on the serial pair.
// Assumes the loader's clock; bit time bt is set by the bench.
`timescale 1ns/1ps
module ubrl_ctrl_model (
    input  wire logic ref_clk_in,
    input  wire logic serial_rx_in,
    output logic      serial_tx_out
);
    int bt = 8; // bit time in cycles
    initial serial_tx_out = 1'b1;
    // one 8n1 frame lsb first; bad pulls the stop bit low
    task automatic send(input logic [7:0] b, input logic bad);
        logic [9:0] f;
        f = {~bad, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk_in);
            serial_tx_out <= f[i];
            repeat (bt - 1) @(posedge ref_clk_in);
        end
        if (bad) serial_tx_out <= 1'b1;
    endtask : send
    // bounded wait for a reply; 9'h100 means the device stayed silent
    task automatic recv(output logic [8:0] r);
        r = 9'h100;
        for (int n = 0; n < 3000 && serial_rx_in; n++) @(posedge ref_clk_in);
        if (!serial_rx_in) begin
            repeat (bt / 2) @(posedge ref_clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (bt) @(posedge ref_clk_in);
                r[i] = serial_rx_in;
            end
            r[8] = 1'b0;
            repeat (bt) @(posedge ref_clk_in);
        end
    endtask : recv
endmodule : ubrl_ctrl_model

// >>> verification/tb_top.sv
// tb_top: self-checking bench for the ram boot loader.
// Assumes the controller model on the serial pair and one clock.
`timescale 1ns/1ps
module tb_top;
    import ubrl_pkg::*;
    logic              ref_clk_in, rst_in, prot, jump, dead, rxen, frac;
    logic              m2d, d2m, jseen;
    logic [95:0]       pwd;
    logic [15:0]       div;
    logic [31:0]       jaddr;
    ubrl_ram_wr_t      wr;
    logic [8:0]        r;
    logic [7:0]        pl[$] = '{8'h3C, 8'hFF, 8'h01};
    int                error_cnt = 0, num_checks = 0, idx = 0;
    ubrl_loader dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .serial_rx_in(m2d), .serial_tx_out(d2m), .protect_active_in(prot),
        .password_in(pwd), .ram_wr_out(wr), .jump_out(jump),
        .jump_addr_out(jaddr), .session_dead_out(dead),
        .receive_enable_bit_out(rxen), .baud_divider_control_out(div),
        .baud_fraction_adjust_out(frac));
    ubrl_ctrl_model m (.ref_clk_in(ref_clk_in), .serial_rx_in(d2m),
        .serial_tx_out(m2d));
    // ----
    // helpers
    // ----
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
            error_cnt++;
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic xfer(input logic [7:0] b, input logic bad, logic [7:0] e);
        m.send(b, bad);
        m.recv(r);
        check(32'(r), {24'h0, e});
    endtask : xfer
    // f: 1 bad sum, 2 rx error and bad sum, 3 password slip
    task automatic field(input logic [7:0] d[$], input int f, e);
        logic [7:0] s;
        s = 8'h00;
        if (f == 3) d[5] = ~d[5];
        foreach (d[i]) s += d[i];
        foreach (d[i]) m.send(d[i], f == 2 && i == 0);
        m.send(~s + 8'h01 + 8'(f inside {1, 2}), 1'b0);
        m.recv(r);
        check(32'(r), e);
    endtask : field
    // ----
    // scenarios
    // ----
    task automatic t_sync_cmd();
        xfer(SYNC_BYTE, 0, SYNC_BYTE);
        check({frac, div}, 32'h8);
        xfer(8'h10, 1, {4'h0, LOW_COMM});
        xfer(8'h55, 0, {4'h0, LOW_BADCMD});
        prot <= 1'b1;
        xfer(CMD_RAM_LOAD, 0, {4'h5, LOW_PROT});
        prot <= 1'b0;
    endtask : t_sync_cmd
    task automatic t_pwd_load();
        logic [7:0] q[$];
        for (int k = 0; k < PWD_BYTES; k++) q.push_back(8'hA0 + 8'(k));
        for (int f = 1; f < 5; f++) begin
            xfer(CMD_RAM_LOAD, 0, CMD_RAM_LOAD);
            field(q, f % 4, f == 2 ? ACK_COMM_ERR : f == 4 ? ACK_OK : ACK_SUM_ERR);
        end
        field('{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h03}, 0, ACK_OK);
        field(pl, 0, ACK_OK);
        for (int n = 0; n < 500 && !jseen; n++) @(posedge ref_clk_in);
        check(jaddr, 32'h1000);
        check(32'(jseen), 1);
        check(idx, 3);
    endtask : t_pwd_load
    task automatic t_dead();
        rst_in <= 1'b1;
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        m.bt = 2;
        m.send(SYNC_BYTE, 0);
        m.recv(r);
        check({r, dead}, 32'h201);
    endtask : t_dead
    // payload write monitor and jump catcher
    always @(posedge ref_clk_in) begin
        if (wr.we) begin
            check(wr.addr, 32'h1000 + idx);
            check(wr.data, pl[idx]);
            idx++;
        end
        if (jump) jseen <= 1'b1;
    end
    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #200us;
        error_cnt++;
        stop_test();
    end
    initial begin
        rst_in <= 1'b1;
        prot <= 1'b0;
        jseen <= 1'b0;
        for (int k = 0; k < PWD_BYTES; k++) pwd[8*k+:8] = 8'hA0 + 8'(k);
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_sync_cmd();
        t_pwd_load();
        t_dead();
        stop_test();
    end
endmodule : tb_top
